// file: verilog/msdb_top.sv
// mode sense data builder: header, block descriptor and format page stream
`timescale 1ns/1ps

// Contract
// (RULE_01) first byte counts following mode bytes
// (RULE_02) write-protect bit always zero
// (RULE_03) descriptor length eight, one descriptor
// (RULE_04) density, block count, reserved all zero
// (RULE_05) saveable flag only on saveable pages
// (RULE_06) format page code 03h, length 16h
// (RULE_07) six tracks per defect zone
// (RULE_08) one alternate sector per zone default
// (RULE_09) alternate tracks per zone/volume zero
// (RULE_10) 92 sectors per track reported
// (RULE_11) 512 bytes per physical sector
// (RULE_12) interleave factor one
// (RULE_13) track skew 19 sectors
// (RULE_14) cylinder skew 25 sectors
// (RULE_15) soft sector one, hard sector zero
// (RULE_16) removable flag zero
// (RULE_17) surface flag zero
// (RULE_18) inhibit save zero, page read-only
// (RULE_19) stop at allocation length or data end
// (RULE_20) page control selects value set
// (RULE_21) block length field 200h
// (RULE_22) reserved bits and bytes zero
module msdb_top (
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic               ce,
    input  wire logic               cmd_start,
    input  wire msdb_pkg::msdb_cmd_t cmd,
    output msdb_pkg::msdb_byte_t     dout,
    output logic                     dout_valid,
    input  wire logic               dout_ready,
    output logic                     busy,
    output logic                     done,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic [31:0]              reg_rdata
);

    logic [1:0]            rst_sync_reg;
    logic                  rst_n;
    msdb_pkg::msdb_state_t state_reg;
    msdb_pkg::msdb_state_t state_next;
    logic [7:0]            idx_reg;
    logic [7:0]            idx_next;
    logic [7:0]            limit_reg;
    logic [7:0]            limit_next;
    logic [1:0]            pcf_reg;
    logic [1:0]            pcf_next;
    msdb_pkg::msdb_byte_t  out_reg;
    msdb_pkg::msdb_byte_t  out_next;
    logic                  valid_reg;
    logic                  valid_next;
    logic [7:0]            sent_reg;
    logic [7:0]            sent_next;
    logic [15:0]           cur_alt_reg;
    logic [15:0]           cur_alt_next;
    logic [15:0]           saved_alt_reg;
    logic [15:0]           saved_alt_next;
    logic [31:0]           rdata_reg;
    logic [31:0]           rdata_next;
    logic                  take;
    logic [7:0]            limit_calc;
    logic [7:0]            first_byte;
    logic [7:0]            next_byte;

    // reset release through two flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'h1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // alternate-sector value of the chosen value set
    function automatic logic [15:0] alt_select(
        input logic [1:0]  pcf,
        input logic [15:0] cur_alt,
        input logic [15:0] saved_alt
    );
        logic [15:0] alt;
        alt = 16'h0000;
        unique case (pcf) // RULE_20
            msdb_pkg::PCF_CURRENT: begin
                alt = cur_alt;
            end
            msdb_pkg::PCF_CHANGEABLE: begin
                alt = 16'h0000; // RULE_18
            end
            msdb_pkg::PCF_DEFAULT: begin
                alt = msdb_pkg::ALT_SECT_DFLT; // RULE_08
            end
            msdb_pkg::PCF_SAVED: begin
                alt = saved_alt;
            end
        endcase
        return alt;
    endfunction

    // header and block descriptor bytes
    function automatic logic [7:0] head_byte(
        input logic [7:0] idx
    );
        logic [7:0] b;
        b = 8'h00; // RULE_22
        unique case (idx)
            msdb_pkg::IDX_HDR_LEN: begin
                b = msdb_pkg::MODE_DATA_LEN; // RULE_01
            end
            msdb_pkg::IDX_HDR_WP: begin
                b = msdb_pkg::HDR_WP_CLEAR; // RULE_02
            end
            msdb_pkg::IDX_HDR_BDL: begin
                b = msdb_pkg::BLK_DESC_LEN; // RULE_03
            end
            msdb_pkg::IDX_BD_DENS: begin
                b = msdb_pkg::DENSITY_CODE; // RULE_04
            end
            msdb_pkg::IDX_BD_RSVD: begin
                b = 8'h00; // RULE_04
            end
            msdb_pkg::IDX_BD_BL0: begin
                b = msdb_pkg::BLOCK_LENGTH[23:16]; // RULE_21
            end
            msdb_pkg::IDX_BD_BL1: begin
                b = msdb_pkg::BLOCK_LENGTH[15:8]; // RULE_21
            end
            msdb_pkg::IDX_BD_BL2: begin
                b = msdb_pkg::BLOCK_LENGTH[7:0]; // RULE_21
            end
            default: begin
                if (idx >= msdb_pkg::IDX_BD_NB0 && idx <= msdb_pkg::IDX_BD_NB2) begin
                    b = msdb_pkg::NUM_BLOCKS_BYTE; // RULE_04
                end
            end
        endcase
        return b;
    endfunction

    // format page bytes, masked when only changeable bits are asked for
    function automatic logic [7:0] page_byte(
        input logic [4:0]  pg,
        input logic [15:0] alt,
        input logic        chg
    );
        logic [7:0] b;
        b = 8'h00; // RULE_22
        unique case (pg)
            msdb_pkg::PG_HDR: begin
                b = {msdb_pkg::FMT_SAVEABLE, 1'h0, msdb_pkg::FMT_PAGE_CODE}; // RULE_05 RULE_06
            end
            msdb_pkg::PG_LEN: begin
                b = msdb_pkg::FMT_PAGE_LEN; // RULE_06
            end
            msdb_pkg::PG_TPZ: begin
                b = msdb_pkg::TRACKS_PER_ZONE[15:8]; // RULE_07
            end
            msdb_pkg::PG_TPZ + 5'h1: begin
                b = msdb_pkg::TRACKS_PER_ZONE[7:0]; // RULE_07
            end
            msdb_pkg::PG_ASZ: begin
                b = alt[15:8]; // RULE_08
            end
            msdb_pkg::PG_ASZ + 5'h1: begin
                b = alt[7:0]; // RULE_08
            end
            msdb_pkg::PG_ATZ: begin
                b = msdb_pkg::ALT_TRK_ZONE[15:8]; // RULE_09
            end
            msdb_pkg::PG_ATZ + 5'h1: begin
                b = msdb_pkg::ALT_TRK_ZONE[7:0]; // RULE_09
            end
            msdb_pkg::PG_ATV: begin
                b = msdb_pkg::ALT_TRK_VOL[15:8]; // RULE_09
            end
            msdb_pkg::PG_ATV + 5'h1: begin
                b = msdb_pkg::ALT_TRK_VOL[7:0]; // RULE_09
            end
            msdb_pkg::PG_SPT: begin
                b = msdb_pkg::SECT_PER_TRACK[15:8]; // RULE_10
            end
            msdb_pkg::PG_SPT + 5'h1: begin
                b = msdb_pkg::SECT_PER_TRACK[7:0]; // RULE_10
            end
            msdb_pkg::PG_BPS: begin
                b = msdb_pkg::BYTES_PER_SECT[15:8]; // RULE_11
            end
            msdb_pkg::PG_BPS + 5'h1: begin
                b = msdb_pkg::BYTES_PER_SECT[7:0]; // RULE_11
            end
            msdb_pkg::PG_ILV: begin
                b = msdb_pkg::INTERLEAVE[15:8]; // RULE_12
            end
            msdb_pkg::PG_ILV + 5'h1: begin
                b = msdb_pkg::INTERLEAVE[7:0]; // RULE_12
            end
            msdb_pkg::PG_TSK: begin
                b = msdb_pkg::TRACK_SKEW[15:8]; // RULE_13
            end
            msdb_pkg::PG_TSK + 5'h1: begin
                b = msdb_pkg::TRACK_SKEW[7:0]; // RULE_13
            end
            msdb_pkg::PG_CSK: begin
                b = msdb_pkg::CYL_SKEW[15:8]; // RULE_14
            end
            msdb_pkg::PG_CSK + 5'h1: begin
                b = msdb_pkg::CYL_SKEW[7:0]; // RULE_14
            end
            msdb_pkg::PG_FLAGS: begin
                b = {msdb_pkg::SOFT_SECTOR, msdb_pkg::HARD_SECTOR, // RULE_15
                     msdb_pkg::REMOVABLE, // RULE_16
                     msdb_pkg::SURFACE_ORDER, // RULE_17
                     msdb_pkg::INHIBIT_SAVE, 3'h0}; // RULE_18
            end
            default: begin
                b = 8'h00; // RULE_22
            end
        endcase
        // changeable mask: nothing on this page may be altered
        if (chg && pg >= msdb_pkg::PG_TPZ) begin
            b = 8'h00; // RULE_20
        end
        return b;
    endfunction

    // one byte of the stream by position
    function automatic logic [7:0] stream_byte(
        input logic [7:0]  idx,
        input logic [1:0]  pcf,
        input logic [15:0] cur_alt,
        input logic [15:0] saved_alt
    );
        logic [4:0] pg;
        logic [7:0] b;
        pg = 5'(idx - msdb_pkg::IDX_PAGE);
        b  = 8'h00; // RULE_22
        if (idx < msdb_pkg::IDX_PAGE) begin
            b = head_byte(idx);
        end else begin
            b = page_byte(pg, alt_select(pcf, cur_alt, saved_alt),
                          pcf == msdb_pkg::PCF_CHANGEABLE);
        end
        return b;
    endfunction

    assign take = valid_reg && dout_ready;

    // bytes to send: allocation length or all data, whichever is less
    always_comb begin
        if (cmd.alloc_len < msdb_pkg::TOTAL_BYTES) begin
            limit_calc = cmd.alloc_len; // RULE_19
        end else begin
            limit_calc = msdb_pkg::TOTAL_BYTES; // RULE_19
        end
        first_byte = stream_byte(8'h00, cmd.page_control_field, cur_alt_reg, saved_alt_reg);
        next_byte  = stream_byte(8'(idx_reg + 8'h01), pcf_reg, cur_alt_reg, saved_alt_reg);
    end

    // stream state
    always_comb begin
        state_next = state_reg;
        idx_next   = idx_reg;
        limit_next = limit_reg;
        pcf_next   = pcf_reg;
        out_next   = out_reg;
        valid_next = valid_reg;
        sent_next  = sent_reg;
        unique case (state_reg)
            msdb_pkg::ST_IDLE: begin
                if (cmd_start) begin
                    pcf_next   = cmd.page_control_field; // RULE_20
                    limit_next = limit_calc;
                    idx_next   = 8'h00;
                    sent_next  = 8'h00;
                    if (limit_calc == 8'h00) begin
                        state_next = msdb_pkg::ST_DONE; // RULE_19
                    end else begin
                        state_next    = msdb_pkg::ST_SEND;
                        out_next.data = first_byte;
                        out_next.last = (limit_calc == 8'h01);
                        valid_next    = 1'h1;
                    end
                end
            end
            msdb_pkg::ST_SEND: begin
                if (take) begin
                    sent_next = 8'(sent_reg + 8'h01);
                    if (out_reg.last) begin
                        out_next   = '0;
                        valid_next = 1'h0;
                        state_next = msdb_pkg::ST_DONE; // RULE_19
                    end else begin
                        idx_next      = 8'(idx_reg + 8'h01);
                        out_next.data = next_byte;
                        out_next.last = (8'(idx_reg + 8'h02) == limit_reg); // RULE_19
                    end
                end
            end
            msdb_pkg::ST_DONE: begin
                state_next = msdb_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= msdb_pkg::ST_IDLE;
            idx_reg   <= 8'h00;
            limit_reg <= 8'h00;
            pcf_reg   <= 2'h0;
            out_reg   <= '0;
            valid_reg <= 1'h0;
            sent_reg  <= 8'h00;
        end else if (ce) begin
            state_reg <= state_next;
            idx_reg   <= idx_next;
            limit_reg <= limit_next;
            pcf_reg   <= pcf_next;
            out_reg   <= out_next;
            valid_reg <= valid_next;
            sent_reg  <= sent_next;
        end
    end

    // register file
    always_comb begin
        cur_alt_next   = cur_alt_reg;
        saved_alt_next = saved_alt_reg;
        rdata_next     = 32'h0000_0000;
        if (reg_wr) begin
            unique case (reg_addr)
                msdb_pkg::REG_CUR_ALT:   cur_alt_next = reg_wdata[15:0];
                msdb_pkg::REG_SAVED_ALT: saved_alt_next = reg_wdata[15:0];
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                msdb_pkg::REG_CUR_ALT:   rdata_next = {16'h0000, cur_alt_reg};
                msdb_pkg::REG_SAVED_ALT: rdata_next = {16'h0000, saved_alt_reg};
                msdb_pkg::REG_STATUS: begin
                    rdata_next = {27'h0, pcf_reg, valid_reg, state_reg == msdb_pkg::ST_DONE,
                                  state_reg != msdb_pkg::ST_IDLE};
                end
                msdb_pkg::REG_COUNT: rdata_next = {16'h0000, limit_reg, sent_reg};
                default:             rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_alt_reg   <= msdb_pkg::ALT_SECT_DFLT; // RULE_08
            saved_alt_reg <= msdb_pkg::ALT_SECT_DFLT; // RULE_08
            rdata_reg     <= 32'h0000_0000;
        end else if (ce) begin
            cur_alt_reg   <= cur_alt_next;
            saved_alt_reg <= saved_alt_next;
            rdata_reg     <= rdata_next;
        end
    end

    assign dout       = out_reg;
    assign dout_valid = valid_reg;
    assign busy       = (state_reg != msdb_pkg::ST_IDLE);
    assign done       = (state_reg == msdb_pkg::ST_DONE);
    assign reg_rdata  = rdata_reg;

endmodule

// file: verilog/msdb_pkg.sv
// constants and types of the mode sense data builder
package msdb_pkg;
    // stream layout
    localparam logic [7:0] TOTAL_BYTES     = 8'h24;
    localparam logic [7:0] MODE_DATA_LEN   = 8'h23;
    localparam logic [7:0] BLK_DESC_LEN    = 8'h08;
    localparam logic [7:0] HDR_WP_CLEAR    = 8'h00;
    localparam logic [7:0] DENSITY_CODE    = 8'h00;
    localparam logic [7:0] NUM_BLOCKS_BYTE = 8'h00;
    localparam logic [23:0] BLOCK_LENGTH   = 24'h000200;
    localparam logic [5:0] FMT_PAGE_CODE   = 6'h03;
    localparam logic [7:0] FMT_PAGE_LEN    = 8'h16;
    localparam logic       FMT_SAVEABLE    = 1'h0;
    // format page values
    localparam logic [15:0] TRACKS_PER_ZONE = 16'h0006;
    localparam logic [15:0] ALT_SECT_DFLT   = 16'h0001;
    localparam logic [15:0] ALT_TRK_ZONE    = 16'h0000;
    localparam logic [15:0] ALT_TRK_VOL     = 16'h0000;
    localparam logic [15:0] SECT_PER_TRACK  = 16'h005c;
    localparam logic [15:0] BYTES_PER_SECT  = 16'h0200;
    localparam logic [15:0] INTERLEAVE      = 16'h0001;
    localparam logic [15:0] TRACK_SKEW      = 16'h0013;
    localparam logic [15:0] CYL_SKEW        = 16'h0019;
    localparam logic       SOFT_SECTOR     = 1'h1;
    localparam logic       HARD_SECTOR     = 1'h0;
    localparam logic       REMOVABLE       = 1'h0;
    localparam logic       SURFACE_ORDER   = 1'h0;
    localparam logic       INHIBIT_SAVE    = 1'h0;
    // byte positions in the stream
    localparam logic [7:0] IDX_HDR_LEN  = 8'h00;
    localparam logic [7:0] IDX_HDR_WP   = 8'h02;
    localparam logic [7:0] IDX_HDR_BDL  = 8'h03;
    localparam logic [7:0] IDX_BD_DENS  = 8'h04;
    localparam logic [7:0] IDX_BD_NB0   = 8'h05;
    localparam logic [7:0] IDX_BD_NB2   = 8'h07;
    localparam logic [7:0] IDX_BD_RSVD  = 8'h08;
    localparam logic [7:0] IDX_BD_BL0   = 8'h09;
    localparam logic [7:0] IDX_BD_BL1   = 8'h0a;
    localparam logic [7:0] IDX_BD_BL2   = 8'h0b;
    localparam logic [7:0] IDX_PAGE     = 8'h0c;
    // format page byte offsets
    localparam logic [4:0] PG_HDR   = 5'h00;
    localparam logic [4:0] PG_LEN   = 5'h01;
    localparam logic [4:0] PG_TPZ   = 5'h02;
    localparam logic [4:0] PG_ASZ   = 5'h04;
    localparam logic [4:0] PG_ATZ   = 5'h06;
    localparam logic [4:0] PG_ATV   = 5'h08;
    localparam logic [4:0] PG_SPT   = 5'h0a;
    localparam logic [4:0] PG_BPS   = 5'h0c;
    localparam logic [4:0] PG_ILV   = 5'h0e;
    localparam logic [4:0] PG_TSK   = 5'h10;
    localparam logic [4:0] PG_CSK   = 5'h12;
    localparam logic [4:0] PG_FLAGS = 5'h14;
    // page control
    localparam logic [1:0] PCF_CURRENT    = 2'h0;
    localparam logic [1:0] PCF_CHANGEABLE = 2'h1;
    localparam logic [1:0] PCF_DEFAULT    = 2'h2;
    localparam logic [1:0] PCF_SAVED      = 2'h3;
    // register map
    localparam logic [7:0] REG_CUR_ALT   = 8'h00;
    localparam logic [7:0] REG_SAVED_ALT = 8'h04;
    localparam logic [7:0] REG_STATUS    = 8'h08;
    localparam logic [7:0] REG_COUNT     = 8'h0c;

    typedef struct packed {
        logic [1:0] page_control_field;
        logic [7:0] alloc_len;
    } msdb_cmd_t;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } msdb_byte_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SEND = 3'b010,
        ST_DONE = 3'b100
    } msdb_state_t;
endpackage

// file: bench/msdb_top_monitor.sv
// checker of the mode sense data builder ports
`timescale 1ns/1ps
module msdb_top_monitor (
    input wire logic                 clk,
    input wire logic                 nrst,
    input wire logic                 ce,
    input wire logic                 cmd_start,
    input wire msdb_pkg::msdb_cmd_t  cmd,
    input wire msdb_pkg::msdb_byte_t dout,
    input wire logic                 dout_valid,
    input wire logic                 dout_ready,
    input wire logic                 busy,
    input wire logic                 done
);
    logic [7:0] pos_reg;
    logic [7:0] pos_next;
    logic [1:0] pcf_reg;
    logic [1:0] pcf_next;
    logic       take;
    logic       start;

    assign take  = ce && dout_valid && dout_ready;
    assign start = ce && cmd_start && !busy;

    // position of the next byte in the stream
    always_comb begin
        pos_next = pos_reg;
        pcf_next = pcf_reg;
        if (start) begin
            pos_next = 8'h00;
            pcf_next = cmd.page_control_field;
        end else if (take) begin
            pos_next = pos_reg + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pos_reg <= 8'h00;
            pcf_reg <= 2'h0;
        end else begin
            pos_reg <= pos_next;
            pcf_reg <= pcf_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_last_needs_valid: assert property (dout.last |-> dout_valid)
        else $error("last flag without valid byte");
    a_hold_until_take: assert property (dout_valid && !dout_ready && ce |=> dout_valid && $stable(dout))
        else $error("byte changed before it was taken");
    a_first_len_byte: assert property (start && cmd.alloc_len != 8'h00 |=> dout_valid && dout.data == 8'h23)
        else $error("first byte is not the length");
    a_zero_alloc_end: assert property (start && cmd.alloc_len == 8'h00 |=> done && !dout_valid)
        else $error("zero allocation did not end at once");
    a_done_after_last: assert property (take && dout.last |=> done && !dout_valid ##1 !busy)
        else $error("no completion after final byte");
    a_last_at_end: assert property (take && pos_reg == 8'h23 |-> dout.last)
        else $error("byte 35 not marked last");
    a_wp_bit_zero: assert property (take && pos_reg == 8'h02 |-> !dout.data[7])
        else $error("write protect set");
    a_desc_len_byte: assert property (take && pos_reg == 8'h03 |-> dout.data == 8'h08)
        else $error("descriptor length wrong");
    a_page_header: assert property (take && pos_reg == 8'h0c |-> dout.data == 8'h03)
        else $error("page header byte wrong");
    a_sector_flags: assert property (take && pos_reg == 8'h20 |-> dout.data == ((pcf_reg == msdb_pkg::PCF_CHANGEABLE) ? 8'h00 : 8'h80))
        else $error("flag byte wrong");

    cover property (take && dout.last);
    cover property (dout_valid && !dout_ready);
    cover property (start && cmd.alloc_len == 8'h00);
endmodule

bind msdb_top msdb_top_monitor mon_u (.clk(clk), .nrst(nrst), .ce(ce), .cmd_start(cmd_start),
    .cmd(cmd), .dout(dout), .dout_valid(dout_valid), .dout_ready(dout_ready), .busy(busy),
    .done(done));

// file: bench/msdb_initiator.sv
// initiator model: accepts stream bytes, stalling on request
`timescale 1ns/1ps
module msdb_initiator (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic stall,
    output logic      dout_ready
);
    logic [1:0] ph_reg;

    // ready each cycle, or one cycle in four while stalling
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ph_reg     <= 2'h0;
            dout_ready <= 1'b0;
        end else begin
            ph_reg     <= ph_reg + 2'h1;
            dout_ready <= !stall || (ph_reg == 2'h3);
        end
    end
endmodule

// file: bench/msdb_tb_top.sv
// self-checking bench of the mode sense data builder
`timescale 1ns/1ps
module msdb_tb_top;
    logic                 clk = 1'b0;
    logic                 nrst = 1'b0;
    logic                 ce = 1'b1;
    logic                 cmd_start = 1'b0;
    msdb_pkg::msdb_cmd_t  cmd = '0;
    msdb_pkg::msdb_byte_t dout;
    logic                 dout_valid, dout_ready, busy, done;
    logic [7:0]           reg_addr = 8'h00;
    logic [31:0]          reg_wdata = 32'h0;
    logic [31:0]          reg_rdata;
    logic                 reg_wr = 1'b0;
    logic                 reg_rd = 1'b0;
    logic                 stall = 1'b0;
    logic [15:0]          cur_alt = 16'h0001;
    logic [15:0]          saved_alt = 16'h0001;
    int                   num_errors = 0;
    int                   cmp_count = 0;
    msdb_pkg::msdb_byte_t rxq[$];
    localparam logic [7:0] IMG [36] = '{8'h23, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h03, 8'h16, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h5c, 8'h02, 8'h00, 8'h00, 8'h01, 8'h00, 8'h13, 8'h00,
        8'h19, 8'h80, 8'h00, 8'h00, 8'h00};

    always #2.5 clk = ~clk;

    msdb_top dut_u (.clk(clk), .nrst(nrst), .ce(ce), .cmd_start(cmd_start), .cmd(cmd),
        .dout(dout), .dout_valid(dout_valid), .dout_ready(dout_ready), .busy(busy),
        .done(done), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    msdb_initiator init_u (.clk(clk), .nrst(nrst), .stall(stall), .dout_ready(dout_ready));

    always @(posedge clk) begin
        if (dout_valid && dout_ready) begin
            rxq.push_back(dout);
        end
    end

    task automatic give_verdict();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(reg_rdata, exp, "register read");
        @(posedge clk);
    endtask

    task automatic run_stream(input logic [1:0] pcf, input logic [7:0] alen);
        logic [7:0] exp [36];
        int         lim;
        int         k;
        exp = IMG;
        lim = (alen > 8'h24) ? 36 : int'(alen);
        case (pcf)
            2'h0: {exp[16], exp[17]} = cur_alt;
            2'h1: for (k = 14; k < 36; k++) exp[k] = 8'h00;
            2'h2: {exp[16], exp[17]} = 16'h0001;
            default: {exp[16], exp[17]} = saved_alt;
        endcase
        rxq.delete();
        cmd       <= '{page_control_field: pcf, alloc_len: alen};
        cmd_start <= 1'b1;
        @(posedge clk);
        cmd_start <= 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 300) begin
            @(negedge clk);
            k++;
        end
        if (done !== 1'b1) begin
            num_errors++;
            give_verdict();
        end
        chk(rxq.size(), lim, "byte count");
        for (k = 0; k < rxq.size() && k < 36; k++) begin
            chk({rxq[k].last, rxq[k].data}, {k == lim - 1, exp[k]}, "stream byte");
        end
        @(posedge clk);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (5) @(posedge clk);
        reg_read(8'h00, 32'h0000_0001);
        reg_read(8'h04, 32'h0000_0001);
        reg_read(8'h10, 32'h0000_0000);
        reg_write(8'h00, 32'hffff_0007);
        reg_write(8'h04, 32'h0000_0009);
        reg_write(8'h30, 32'h0000_00ff);
        ce <= 1'b0;
        reg_write(8'h04, 32'h0000_0005);
        ce <= 1'b1;
        reg_read(8'h04, 32'h0000_0009);
        reg_read(8'h00, 32'h0000_0007);
        reg_read(8'h30, 32'h0000_0000);
        cur_alt   = 16'h0007;
        saved_alt = 16'h0009;
        for (int p = 0; p < 4; p++) begin
            stall <= p[0];
            run_stream(p[1:0], 8'hff);
        end
        run_stream(2'h0, 8'h05);
        reg_read(8'h0c, 32'h0000_0505);
        stall <= 1'b1;
        run_stream(2'h3, 8'h24);
        run_stream(2'h2, 8'h00);
        reg_read(8'h08, 32'h0000_0010);
        give_verdict();
    end
endmodule
